//--- flash_status_pkg.sv
// Constants, types and command codes for the status and protection bank
//
// How it works
// RL1: Bottom select 0 top, 1 bottom
// RL2: Bottom select resets 0, status write only
// RL3: Invert bit at S14 flips protected region
// RL4: Guard bits S8, S7 choose write protection
// RL5: Guard 00: pin ignored, latch permits write
// RL6: Guard 01: pin low blocks status writes
// RL7: Guard 10: writes locked until power cycle
// RL8: Guard 11: status writes refused forever; reset clears it, as for 10
// RL9: Suspend flag S15 set 75h, cleared 7Ah
// RL10: Security lock bits set once, never cleared; reset clears them
// RL11: Quad turns protect and pause pins data
// RL12: 38h ignored unless quad is set
// RL13: In four-wire mode quad cannot clear
// RL14: Width flag reports current address width
// RL15: Power-up width used at init, 06h+11h
// RL16: Init enters width chosen at power-up
// RL17: Scheme select picks block bits or locks
// RL18: All block locks set at reset
// RL19: Drive select picks strength, default 11
// RL20: Shared pin picks pause or restart
// RL21: Reserved bits ignored on write
// RL22: Level at S5..S2, default zero
// RL23: Write latch set by 06h, cleared otherwise
// RL24: Protected erase or program is ignored
// RL25: Read-only bits ignore written data
package flash_status_pkg;

   // ------------------------------------------------------------
   // Command codes
   // ------------------------------------------------------------
   localparam logic [7:0] CMD_WREN = 8'h06;
   localparam logic [7:0] CMD_WRDI = 8'h04;
   localparam logic [7:0] CMD_RDSR1 = 8'h05;
   localparam logic [7:0] CMD_RDSR2 = 8'h35;
   localparam logic [7:0] CMD_RDSR3 = 8'h15;
   localparam logic [7:0] CMD_WRSR1 = 8'h01;
   localparam logic [7:0] CMD_WRSR2 = 8'h31;
   localparam logic [7:0] CMD_WRSR3 = 8'h11;
   localparam logic [7:0] CMD_SUSPEND = 8'h75;
   localparam logic [7:0] CMD_RESUME = 8'h7A;
   localparam logic [7:0] CMD_ENTER_4W = 8'h38;
   localparam logic [7:0] CMD_EXIT_4W = 8'hFF;
   localparam logic [7:0] CMD_ENTER_4B = 8'hB7;
   localparam logic [7:0] CMD_EXIT_4B = 8'hE9;
   localparam logic [7:0] CMD_BLK_LOCK = 8'h36;
   localparam logic [7:0] CMD_BLK_UNLOCK = 8'h39;

   // ------------------------------------------------------------
   // Sizes, field positions and reset values
   // ------------------------------------------------------------
   localparam int BLOCKS = 512;
   localparam int BLK_W = 9;
   localparam logic [3:0] LEVEL_ALL = 4'hA;
   localparam logic [BLK_W-1:0] BLK_TOP = 9'h1FF;
   localparam logic [1:0] BYTES_CMD = 2'h1;
   localparam logic [1:0] BYTES_WR = 2'h2;
   localparam logic [1:0] BYTES_LOCK = 2'h3;
   localparam logic [2:0] BIT_LAST = 3'h7;
   // Synchroniser idle: CS high, clock low, data low, WP and HOLD high
   localparam logic [4:0] PIN_IDLE = 5'h19;
   localparam int PIN_CS = 0;
   localparam int PIN_SCLK = 1;
   localparam int PIN_DI = 2;
   localparam int PIN_WP = 3;
   localparam int PIN_HOLD = 4;
   localparam logic [3:0] BP_RST = 4'h0;
   localparam logic [2:0] LB_RST = 3'h0;
   localparam logic [1:0] DRV_RST = 2'h3;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_CMD = 2'h1,
      ST_DATA = 2'h3
   } link_state_e;

   typedef enum logic [1:0] {
      PIN_PAUSE = 2'h0,
      PIN_RESTART = 2'h1,
      PIN_DATA = 2'h2
   } pin_func_e;

   // Configuration bits held by the bank
   typedef struct packed {
      logic guard_hi;
      logic guard_lo;
      logic bottom;
      logic [3:0] bp;
      logic invert;
      logic [2:0] lb;
      logic quad;
      logic pwr_wide;
      logic scheme;
      logic [1:0] drv;
      logic hold_sel;
   } cfg_s;

   localparam cfg_s CFG_RST = '{guard_hi: 1'b0, guard_lo: 1'b0, bottom: 1'b0, bp: BP_RST,
      invert: 1'b0, lb: LB_RST, quad: 1'b0, pwr_wide: 1'b0, scheme: 1'b0, drv: DRV_RST,
      hold_sel: 1'b0};

endpackage : flash_status_pkg

//--- flash_status_config_protect.sv
// Status and configuration bank with protection decisions, serial access
`timescale 1ns/10ps
module flash_status_config_protect
   import flash_status_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic RST_B,
   input wire logic CE,
   input wire logic CS_N,
   input wire logic SCLK,
   input wire logic DI,
   input wire logic WP_IO2_IN,
   input wire logic HOLD_IO3_IN,
   output logic DO,
   output logic DO_OE,
   input wire logic OP_REQ,
   input wire logic [BLK_W-1:0] OP_BLOCK,
   output logic OP_DONE,
   output logic OP_ALLOWED,
   output logic [1:0] DRIVE_STRENGTH,
   output pin_func_e PIN3_FUNC,
   output logic WP_PIN_ACTIVE,
   output logic FOUR_WIRE_MODE,
   output logic ADDR_4BYTE
);

   // ------------------------------------------------------------
   // Pin synchronisers and edge detection
   // ------------------------------------------------------------
   logic [4:0] sync1_reg;
   logic [4:0] sync2_reg;
   logic [4:0] prev_reg;

   // Two flops per pin, then one more for edges
   always_ff @(posedge CLK_SYS) begin
      if (!RST_B) begin
         sync1_reg <= PIN_IDLE;
         sync2_reg <= PIN_IDLE;
         prev_reg <= PIN_IDLE;
      end else if (CE) begin
         sync1_reg <= {HOLD_IO3_IN, WP_IO2_IN, DI, SCLK, CS_N};
         sync2_reg <= sync1_reg;
         prev_reg <= sync2_reg;
      end
   end

   cfg_s cfg_reg;
   cfg_s cfg_next;
   logic wr_en_reg;
   logic wr_en_next;
   logic susp_reg;
   logic susp_next;
   logic four_w_reg;
   logic four_w_next;
   logic wide_reg;
   logic wide_next;

   wire cs_low = ~sync2_reg[PIN_CS];
   wire hold_low = ~sync2_reg[PIN_HOLD];
   // Shared pin works as pause or restart only without quad
   wire pause = CE & ~cfg_reg.quad & ~cfg_reg.hold_sel & hold_low & cs_low; // [RL20]
   wire restart = CE & ~cfg_reg.quad & cfg_reg.hold_sel & hold_low; // [RL20]
   wire edge_ok = CE & cs_low & ~pause;
   wire sclk_rise = edge_ok & sync2_reg[PIN_SCLK] & ~prev_reg[PIN_SCLK];
   wire sclk_fall = edge_ok & ~sync2_reg[PIN_SCLK] & prev_reg[PIN_SCLK];
   wire cs_rise = CE & sync2_reg[PIN_CS] & ~prev_reg[PIN_CS] & ~restart;

   // ------------------------------------------------------------
   // Serial byte capture and link state
   // ------------------------------------------------------------
   link_state_e state_reg;
   link_state_e state_next;
   logic [2:0] bit_cnt_reg;
   logic [1:0] byte_cnt_reg;
   logic [6:0] shift_reg;
   logic [7:0] cmd_reg;
   logic [7:0] d1_reg;
   logic [7:0] d2_reg;
   logic [7:0] tx_reg;

   wire rx_done = sclk_rise & (bit_cnt_reg == BIT_LAST);
   wire [7:0] rx_byte = {shift_reg, sync2_reg[PIN_DI]};
   wire [1:0] byte_cnt_inc = (byte_cnt_reg == BYTES_LOCK) ? byte_cnt_reg
                             : byte_cnt_reg + 2'h1;

   // Link state: idle, command byte, data bytes
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_IDLE: if (cs_low) state_next = ST_CMD;
         ST_CMD: if (!cs_low) state_next = ST_IDLE;
                 else if (rx_done) state_next = ST_DATA;
         ST_DATA: if (!cs_low) state_next = ST_IDLE;
      endcase
   end

   // Shift in MSB first on rising clock edges
   always_ff @(posedge CLK_SYS) begin
      if (!RST_B || restart) begin
         state_reg <= ST_IDLE;
         bit_cnt_reg <= 3'h0;
         byte_cnt_reg <= 2'h0;
         shift_reg <= 7'h00;
      end else if (CE) begin
         state_reg <= state_next;
         if (!cs_low) begin
            bit_cnt_reg <= 3'h0;
            byte_cnt_reg <= 2'h0;
         end else if (sclk_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            shift_reg <= rx_byte[6:0];
            if (rx_done) byte_cnt_reg <= byte_cnt_inc;
         end
      end
   end

   // Hold command and up to two data bytes
   always_ff @(posedge CLK_SYS) begin
      if (!RST_B) begin
         cmd_reg <= 8'h00;
         d1_reg <= 8'h00;
         d2_reg <= 8'h00;
      end else if (CE && rx_done) begin
         if (byte_cnt_reg == 2'h0) cmd_reg <= rx_byte;
         if (byte_cnt_reg == BYTES_CMD) d1_reg <= rx_byte;
         if (byte_cnt_reg == BYTES_WR) d2_reg <= rx_byte;
      end
   end

   // ------------------------------------------------------------
   // Status images and read-out
   // ------------------------------------------------------------
   // Read-only and reserved positions come from state, not writes
   wire [7:0] sr1 = {cfg_reg.guard_lo, cfg_reg.bottom, cfg_reg.bp, wr_en_reg, 1'b0};
   wire [7:0] sr2 = {susp_reg, cfg_reg.invert, cfg_reg.lb, 1'b0, cfg_reg.quad,
                     cfg_reg.guard_hi};
   wire [7:0] sr3 = {cfg_reg.hold_sel, cfg_reg.drv, 2'b00, cfg_reg.scheme, cfg_reg.pwr_wide,
                     wide_reg}; // [RL14]
   wire is_read = (cmd_reg == CMD_RDSR1) | (cmd_reg == CMD_RDSR2) | (cmd_reg == CMD_RDSR3);
   wire [7:0] rd_sel = (rx_byte == CMD_RDSR1) ? sr1
                       : (rx_byte == CMD_RDSR2) ? sr2 : sr3;

   // Load image at command end, shift out on falling edges
   always_ff @(posedge CLK_SYS) begin
      if (!RST_B) begin
         tx_reg <= 8'h00;
         DO <= 1'b0;
      end else if (CE) begin
         if (rx_done && byte_cnt_reg == 2'h0) begin
            tx_reg <= rd_sel;
         end else if (sclk_fall && state_reg == ST_DATA) begin
            DO <= tx_reg[7];
            tx_reg <= {tx_reg[6:0], tx_reg[7]};
         end
      end
   end

   assign DO_OE = (state_reg == ST_DATA) & is_read & cs_low & ~pause;

   // ------------------------------------------------------------
   // Command execution at chip-select release
   // ------------------------------------------------------------
   wire exec1 = cs_rise & (byte_cnt_reg == BYTES_CMD);
   wire exec2 = cs_rise & (byte_cnt_reg == BYTES_WR);
   wire exec3 = cs_rise & (byte_cnt_reg == BYTES_LOCK);
   wire is_wrsr = (cmd_reg == CMD_WRSR1) | (cmd_reg == CMD_WRSR2) | (cmd_reg == CMD_WRSR3);
   // Pin counts only while it is not a data line
   wire wp_high = cfg_reg.quad | sync2_reg[PIN_WP]; // [RL11]
   wire srp_ok = ({cfg_reg.guard_hi, cfg_reg.guard_lo} == 2'b00) // [RL5]
               | (({cfg_reg.guard_hi, cfg_reg.guard_lo} == 2'b01) & wp_high); // [RL6] [RL7] [RL8]
   wire wr_accept = wr_en_reg & srp_ok;
   wire op_req = CE & OP_REQ;

   // Next values of the bank
   always_comb begin
      cfg_next = cfg_reg;
      wr_en_next = wr_en_reg;
      susp_next = susp_reg;
      four_w_next = four_w_reg;
      wide_next = wide_reg;
      if (restart) begin
         wr_en_next = 1'b0;
         susp_next = 1'b0;
         four_w_next = 1'b0;
         wide_next = cfg_reg.pwr_wide; // [RL15] [RL16]
      end else begin
         if (op_req) wr_en_next = 1'b0; // [RL23]
         if (exec1) begin
            if (cmd_reg == CMD_WREN) wr_en_next = 1'b1; // [RL23]
            if (cmd_reg == CMD_WRDI) wr_en_next = 1'b0;
            if (cmd_reg == CMD_SUSPEND) susp_next = 1'b1; // [RL9]
            if (cmd_reg == CMD_RESUME) susp_next = 1'b0; // [RL9]
            if (cmd_reg == CMD_ENTER_4W && cfg_reg.quad) four_w_next = 1'b1; // [RL12]
            if (cmd_reg == CMD_EXIT_4W) four_w_next = 1'b0;
            if (cmd_reg == CMD_ENTER_4B) wide_next = 1'b1; // [RL14]
            if (cmd_reg == CMD_EXIT_4B) wide_next = 1'b0;
         end
         if (exec2 && is_wrsr) begin
            wr_en_next = 1'b0; // [RL23]
            if (wr_accept && cmd_reg == CMD_WRSR1) begin
               cfg_next.guard_lo = d1_reg[7]; // [RL4]
               cfg_next.bottom = d1_reg[6]; // [RL2]
               cfg_next.bp = d1_reg[5:2]; // [RL22] [RL25]
            end
            if (wr_accept && cmd_reg == CMD_WRSR2) begin
               cfg_next.guard_hi = d1_reg[0]; // [RL4]
               cfg_next.quad = d1_reg[1] | (four_w_reg & cfg_reg.quad); // [RL13]
               cfg_next.lb = cfg_reg.lb | d1_reg[5:3]; // [RL10]
               cfg_next.invert = d1_reg[6]; // [RL3] [RL21] [RL25]
            end
            if (wr_accept && cmd_reg == CMD_WRSR3) begin
               cfg_next.pwr_wide = d1_reg[1]; // [RL15]
               cfg_next.scheme = d1_reg[2]; // [RL17]
               cfg_next.drv = d1_reg[6:5]; // [RL19]
               cfg_next.hold_sel = d1_reg[7]; // [RL20] [RL21] [RL25]
            end
         end
      end
   end

   // Bank storage; power-on loads factory defaults
   always_ff @(posedge CLK_SYS) begin
      if (!RST_B) begin
         cfg_reg <= CFG_RST; // [RL2] [RL7]
         wr_en_reg <= 1'b0;
         susp_reg <= 1'b0;
         four_w_reg <= 1'b0;
         wide_reg <= 1'b0;
      end else if (CE) begin
         cfg_reg <= cfg_next;
         wr_en_reg <= wr_en_next;
         susp_reg <= susp_next;
         four_w_reg <= four_w_next;
         wide_reg <= wide_next;
      end
   end

   // ------------------------------------------------------------
   // Individual block locks
   // ------------------------------------------------------------
   logic [BLOCKS-1:0] lock_reg;
   wire [BLK_W-1:0] lock_idx = {d1_reg[0], d2_reg};
   wire lock_wr = exec3 & ((cmd_reg == CMD_BLK_LOCK) | (cmd_reg == CMD_BLK_UNLOCK));

   // One lock flop per block, all set at reset and restart
   for (genvar i = 0; i < BLOCKS; i++) begin : g_lock
      always_ff @(posedge CLK_SYS) begin
         if (!RST_B || restart) begin
            lock_reg[i] <= 1'b1; // [RL18]
         end else if (CE && lock_wr && lock_idx == BLK_W'(i)) begin
            lock_reg[i] <= (cmd_reg == CMD_BLK_LOCK);
         end
      end
   end

   // ------------------------------------------------------------
   // Array protection decision
   // ------------------------------------------------------------
   wire [3:0] lvl = cfg_reg.bp;
   wire [3:0] span_sh = lvl - 4'h1;
   wire [BLK_W-1:0] blk_hi = OP_BLOCK >> span_sh;
   wire in_top = blk_hi == (BLK_TOP >> span_sh);
   wire in_bot = blk_hi == '0;
   wire region = (lvl == 4'h0) ? 1'b0
                 : (lvl >= LEVEL_ALL) ? 1'b1
                 : (cfg_reg.bottom ? in_bot : in_top); // [RL1] [RL22]
   wire bp_prot = region ^ cfg_reg.invert; // [RL3]
   wire prot = cfg_reg.scheme ? lock_reg[OP_BLOCK] : bp_prot; // [RL17]

   // Erase or program request answered the next cycle
   always_ff @(posedge CLK_SYS) begin
      if (!RST_B) begin
         OP_DONE <= 1'b0;
         OP_ALLOWED <= 1'b0;
      end else if (CE) begin
         OP_DONE <= OP_REQ;
         if (OP_REQ) OP_ALLOWED <= wr_en_reg & ~prot; // [RL24]
      end
   end

   // Pin roles and status outputs
   assign DRIVE_STRENGTH = cfg_reg.drv; // [RL19]
   assign PIN3_FUNC = cfg_reg.quad ? PIN_DATA : (cfg_reg.hold_sel ? PIN_RESTART : PIN_PAUSE);
   assign WP_PIN_ACTIVE = ~cfg_reg.quad; // [RL11]
   assign FOUR_WIRE_MODE = four_w_reg;
   assign ADDR_4BYTE = wide_reg;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_B);

   sequence s_wrsr_exec;
      exec2 & is_wrsr;
   endsequence
   sequence s_locked_write;
      s_wrsr_exec ##0 cfg_reg.guard_hi;
   endsequence

   property p_lockdown_refuse; // [RL7] [RL8]
      s_locked_write |=> $stable(cfg_reg);
   endproperty
   a_lockdown_refuse: assert property (p_lockdown_refuse) else $error("locked status written");

   property p_wp_refuse; // [RL6]
      (s_wrsr_exec ##0 ({cfg_reg.guard_hi, cfg_reg.guard_lo} == 2'b01) && !cfg_reg.quad
         && !sync2_reg[PIN_WP]) |=> $stable(cfg_reg);
   endproperty
   a_wp_refuse: assert property (p_wp_refuse) else $error("write passed low protect pin");

   property p_wr_en_clear; // [RL23]
      s_wrsr_exec |=> !wr_en_reg;
   endproperty
   a_wr_en_clear: assert property (p_wr_en_clear) else $error("write enable latch kept");

   property p_enter_4w_gate; // [RL12]
      (exec1 && cmd_reg == CMD_ENTER_4W && !cfg_reg.quad && !four_w_reg) |=> !four_w_reg;
   endproperty
   a_enter_4w_gate: assert property (p_enter_4w_gate) else $error("four-wire without quad");

   property p_quad_held; // [RL13]
      four_w_reg |-> cfg_reg.quad;
   endproperty
   a_quad_held: assert property (p_quad_held) else $error("quad cleared in four-wire mode");

   property p_lb_sticky; // [RL10]
      ##1 ((cfg_reg.lb & $past(cfg_reg.lb)) == $past(cfg_reg.lb));
   endproperty
   a_lb_sticky: assert property (p_lb_sticky) else $error("security lock bit cleared");

   property p_restart_init; // [RL16] [RL18]
      restart |=> (&lock_reg) && (wide_reg == $past(cfg_reg.pwr_wide)) && !wr_en_reg;
   endproperty
   a_restart_init: assert property (p_restart_init) else $error("restart init wrong");

   property p_suspend; // [RL9]
      (exec1 && cmd_reg == CMD_SUSPEND && !restart) |=> susp_reg;
   endproperty
   a_suspend: assert property (p_suspend) else $error("suspend flag not set");

   property p_top_block; // [RL1] [RL24]
      (CE && OP_REQ && !cfg_reg.scheme && !cfg_reg.invert && !cfg_reg.bottom && cfg_reg.bp == 4'h1
         && OP_BLOCK == BLK_TOP) |=> OP_DONE && !OP_ALLOWED;
   endproperty
   a_top_block: assert property (p_top_block) else $error("top block not protected");

   property p_pin_data; // [RL20]
      cfg_reg.quad |-> (PIN3_FUNC == PIN_DATA) && !pause && !restart;
   endproperty
   a_pin_data: assert property (p_pin_data) else $error("shared pin active with quad");

endmodule : flash_status_config_protect

//--- spi_host_model.sv
// Serial host that frames status commands toward the bank, mode 0
`timescale 1ns/10ps
module spi_host_model (
   output logic cs_n,
   output logic sclk,
   output logic di,
   input wire logic dev_out,
   input wire logic dev_oe
);
   // Half of the 48 ns link period
   localparam time HALF = 24ns;

   // Idle link: deselected, clock parked low
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      di = 1'b0;
   end

   // Select, then give the synchroniser time before the first edge
   task automatic frame_start();
      cs_n = 1'b0;
      #HALF;
   endtask : frame_start

   // One byte MSB first; a read bit counts only while the bank drives
   task automatic xfer_byte(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         di = tx[i];
         #HALF;
         sclk = 1'b1;
         rx[i] = dev_oe ? dev_out : 1'bx;
         #HALF;
         sclk = 1'b0;
      end
   endtask : xfer_byte

   // Deselect, flip the released data line, leave room for execution
   task automatic frame_end();
      #HALF;
      cs_n = 1'b1;
      di = ~di;
      #(4 * HALF);
   endtask : frame_end
endmodule : spi_host_model

//--- tb_top.sv
// Self-checking bench for the status, configuration and protection bank
`timescale 1ns/10ps
module tb_top
   import flash_status_pkg::*;
;
   logic CLK_SYS, RST_B, CE, CS_N, SCLK, DI, WP_IO2_IN, HOLD_IO3_IN, DO, DO_OE;
   logic OP_REQ, OP_DONE, OP_ALLOWED, WP_PIN_ACTIVE, FOUR_WIRE_MODE, ADDR_4BYTE;
   logic [BLK_W-1:0] OP_BLOCK;
   logic [1:0] DRIVE_STRENGTH;
   pin_func_e PIN3_FUNC;
   int fail_count = 0;
   int checks_done = 0;

   // 250 MHz system clock
   initial begin
      CLK_SYS = 1'b0;
      forever #2 CLK_SYS = ~CLK_SYS;
   end

   spi_host_model host (.cs_n(CS_N), .sclk(SCLK), .di(DI), .dev_out(DO), .dev_oe(DO_OE));

   flash_status_config_protect DUT (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .CE(CE), .CS_N(CS_N),
      .SCLK(SCLK), .DI(DI), .WP_IO2_IN(WP_IO2_IN), .HOLD_IO3_IN(HOLD_IO3_IN), .DO(DO),
      .DO_OE(DO_OE), .OP_REQ(OP_REQ), .OP_BLOCK(OP_BLOCK), .OP_DONE(OP_DONE),
      .OP_ALLOWED(OP_ALLOWED), .DRIVE_STRENGTH(DRIVE_STRENGTH), .PIN3_FUNC(PIN3_FUNC),
      .WP_PIN_ACTIVE(WP_PIN_ACTIVE), .FOUR_WIRE_MODE(FOUR_WIRE_MODE),
      .ADDR_4BYTE(ADDR_4BYTE));

   // ------------------------------------------------------------
   // Helper tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic chkb(input logic got, input logic exp);
      chk({7'h00, got}, {7'h00, exp});
   endtask : chkb

   task automatic tdone(input string name);
      $display("%s done, fails %0d", name, fail_count);
   endtask : tdone

   task automatic do_reset();
      @(negedge CLK_SYS);
      RST_B = 1'b0;
      repeat (6) @(negedge CLK_SYS);
      RST_B = 1'b1;
      repeat (4) @(negedge CLK_SYS);
   endtask : do_reset

   // One frame of one to three bytes; r holds the last byte read
   task automatic fr(input int n, input logic [7:0] b0, b1, b2, output logic [7:0] r);
      host.frame_start();
      host.xfer_byte(b0, r);
      if (n > 1) host.xfer_byte(b1, r);
      if (n > 2) host.xfer_byte(b2, r);
      host.frame_end();
   endtask : fr

   task automatic cmd(input logic [7:0] c);
      logic [7:0] r;
      fr(1, c, 8'h00, 8'h00, r);
   endtask : cmd

   // Status writes always follow a write enable
   task automatic wr(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] r;
      cmd(CMD_WREN);
      fr(2, c, d, 8'h00, r);
   endtask : wr

   task automatic rdc(input logic [7:0] c, input logic [7:0] exp);
      logic [7:0] r;
      fr(2, c, 8'h00, 8'h00, r);
      chk(r, exp);
   endtask : rdc

   task automatic op(input logic [BLK_W-1:0] blk, input logic exp);
      @(negedge CLK_SYS);
      OP_REQ = 1'b1;
      OP_BLOCK = blk;
      @(negedge CLK_SYS);
      OP_REQ = 1'b0;
      chkb(OP_DONE, 1'b1);
      chkb(OP_ALLOWED, exp);
   endtask : op

   task automatic opw(input logic [BLK_W-1:0] blk, input logic exp);
      cmd(CMD_WREN);
      op(blk, exp);
   endtask : opw

   task automatic end_sim();
      $display("checks %0d fails %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_sim

   // Watchdog well beyond the expected run
   initial begin
      #300us;
      fail_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      end_sim();
   end

   // ------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------
   initial begin
      RST_B = 1'b0;
      CE = 1'b1;
      WP_IO2_IN = 1'b1;
      HOLD_IO3_IN = 1'b1;
      OP_REQ = 1'b0;
      OP_BLOCK = '0;
      do_reset();
      rdc(CMD_RDSR1, 8'h00);
      rdc(CMD_RDSR2, 8'h00);
      rdc(CMD_RDSR3, 8'h60);
      chk({6'h00, PIN3_FUNC}, 8'h00);
      chkb(WP_PIN_ACTIVE, 1'b1);
      chkb(ADDR_4BYTE, 1'b0);
      tdone("defaults");
      cmd(CMD_WREN);
      rdc(CMD_RDSR1, 8'h02);
      cmd(CMD_WRDI);
      rdc(CMD_RDSR1, 8'h00);
      fr(2, CMD_WRSR1, 8'h04, 8'h00, OP_BLOCK[7:0]);
      rdc(CMD_RDSR1, 8'h00);
      tdone("latch");
      wr(CMD_WRSR1, 8'h04);
      rdc(CMD_RDSR1, 8'h04);
      opw(9'h1FF, 1'b0);
      opw(9'h1FE, 1'b1);
      op(9'h1FE, 1'b0);
      wr(CMD_WRSR1, 8'h44);
      opw(9'h000, 1'b0);
      opw(9'h1FF, 1'b1);
      wr(CMD_WRSR2, 8'h40);
      opw(9'h000, 1'b1);
      opw(9'h001, 1'b0);
      wr(CMD_WRSR1, 8'h00);
      wr(CMD_WRSR2, 8'h00);
      tdone("range");
      wr(CMD_WRSR3, 8'h04);
      rdc(CMD_RDSR3, 8'h04);
      opw(9'h105, 1'b0);
      fr(3, CMD_BLK_UNLOCK, 8'h01, 8'h05, OP_BLOCK[7:0]);
      opw(9'h105, 1'b1);
      fr(3, CMD_BLK_LOCK, 8'h01, 8'h05, OP_BLOCK[7:0]);
      opw(9'h105, 1'b0);
      for (int i = 0; i < 4; i++) begin
         wr(CMD_WRSR3, {1'b0, 2'(i), 5'h00});
         chk({6'h00, DRIVE_STRENGTH}, 8'(i));
      end
      wr(CMD_WRSR3, 8'h19);
      rdc(CMD_RDSR3, 8'h00);
      chkb(ADDR_4BYTE, 1'b0);
      tdone("scheme");
      cmd(CMD_ENTER_4B);
      rdc(CMD_RDSR3, 8'h01);
      cmd(CMD_EXIT_4B);
      chkb(ADDR_4BYTE, 1'b0);
      wr(CMD_WRSR3, 8'h82);
      chk({6'h00, PIN3_FUNC}, {6'h00, PIN_RESTART});
      @(negedge CLK_SYS);
      HOLD_IO3_IN = 1'b0;
      repeat (8) @(negedge CLK_SYS);
      HOLD_IO3_IN = 1'b1;
      repeat (8) @(negedge CLK_SYS);
      chkb(ADDR_4BYTE, 1'b1);
      wr(CMD_WRSR3, 8'h60);
      cmd(CMD_EXIT_4B);
      tdone("address");
      cmd(CMD_SUSPEND);
      rdc(CMD_RDSR2, 8'h80);
      wr(CMD_WRSR2, 8'h00);
      rdc(CMD_RDSR2, 8'h80);
      cmd(CMD_RESUME);
      rdc(CMD_RDSR2, 8'h00);
      cmd(CMD_ENTER_4W);
      chkb(FOUR_WIRE_MODE, 1'b0);
      wr(CMD_WRSR2, 8'h02);
      chkb(WP_PIN_ACTIVE, 1'b0);
      chk({6'h00, PIN3_FUNC}, {6'h00, PIN_DATA});
      cmd(CMD_ENTER_4W);
      chkb(FOUR_WIRE_MODE, 1'b1);
      wr(CMD_WRSR2, 8'h00);
      rdc(CMD_RDSR2, 8'h02);
      cmd(CMD_EXIT_4W);
      wr(CMD_WRSR2, 8'h08);
      wr(CMD_WRSR2, 8'h00);
      rdc(CMD_RDSR2, 8'h08);
      wr(CMD_WRSR2, 8'h38);
      tdone("modes");
      wr(CMD_WRSR1, 8'h80);
      @(negedge CLK_SYS);
      WP_IO2_IN = 1'b0;
      wr(CMD_WRSR1, 8'h84);
      rdc(CMD_RDSR1, 8'h80);
      @(negedge CLK_SYS);
      WP_IO2_IN = 1'b1;
      wr(CMD_WRSR1, 8'h84);
      rdc(CMD_RDSR1, 8'h84);
      wr(CMD_WRSR1, 8'h00);
      wr(CMD_WRSR2, 8'h01);
      wr(CMD_WRSR1, 8'h04);
      rdc(CMD_RDSR1, 8'h00);
      do_reset();
      rdc(CMD_RDSR2, 8'h00);
      wr(CMD_WRSR1, 8'h80);
      wr(CMD_WRSR2, 8'h01);
      wr(CMD_WRSR1, 8'h00);
      rdc(CMD_RDSR1, 8'h80);
      wr(CMD_WRSR2, 8'h00);
      rdc(CMD_RDSR2, 8'h01);
      tdone("lockdown");
      end_sim();
   end
endmodule : tb_top
